// >>> shared/logic_ops_defs.svh
`ifndef LOGIC_OPS_DEFS_SVH
`define LOGIC_OPS_DEFS_SVH
// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define OFS_CFG_LOGIC 8'h00
`define OFS_CFG_CMP 8'h04
`define OFS_CFG_MEM 8'h08
`define OFS_CFG_RST 8'h0c
`define OFS_STATUS 8'h10
`define OFS_NV_COUNT 8'h14
`define OFS_INV_BASE 8'h20
// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define F_PAR_N 3:0
`define F_MAC_N1 7:4
`define F_MAC_N2 11:8
`define F_MAC_OP1 14:12
`define F_MAC_OP2 17:15
`define F_MAC_OP3 20:18
`define B_MAC_OUT_DIS 21
`define B_MAC_S1_EN 22
`define B_MAC_S2_EN 23
`define F_MUX_N 26:24
`define B_CMP_SIG 27
`define F_CMP_REL 30:28
`define F_CMP_CONST 7:0
`define F_CMP_N 11:8
`define F_TFF_CLR_EN 15:0
`define F_SR_PERSIST 23:16
`define B_ST_NV_BUSY 7
`define B_ST_NV_TMO 8
`define B_ST_WEAR 9
// ----------------------------------------------------------------------
// Reset values, limits and timing
// ----------------------------------------------------------------------
`define CFG_LOGIC_RST 32'h0200_0112
`define CFG_CMP_RST 32'h0000_0800
`define CFG_MEM_RST 32'h0000_0000
`define CFG_RST_RST 32'h0000_0000
`define PAR_N_MIN 4'h2
`define PAR_N_MAX 4'h8
`define MAC_N_MIN 4'h1
`define MAC_N_MAX 4'h7
`define MUX_N_MIN 4'h2
`define MUX_N_MAX 4'h4
`define CMP_N_MIN 4'h2
`define CMP_N_MAX 4'h8
`define CLK_HZ 40000000
`define NV_WRITE_MS 50
`define NV_WEAR_LIMIT 100000
`define BLINK_HZ 1
`endif

// >>> shared/logic_ops_pkg.sv
package logic_ops_pkg;
	typedef enum logic [2:0] {GATE_AND, GATE_NAND, GATE_OR, GATE_NOR, GATE_XOR, GATE_XNOR,
		GATE_SRFF} gate_op_t;
	typedef enum logic [2:0] {REL_LT, REL_LE, REL_GT, REL_GE, REL_EQ, REL_NE} cmp_rel_t;
	typedef enum logic {NV_IDLE, NV_WRITE} nv_state_t;
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
		logic [3:0] pstrb;
	} apb_req_t;
	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} apb_rsp_t;
	typedef struct packed {
		logic cmp_out;
		logic mux_out;
		logic second_stage_result;
		logic first_stage_result;
		logic mac_out;
		logic even_par;
		logic odd_par;
	} logic_out_t;
endpackage

// >>> verif/nv_store_model.sv
`timescale 1ns/10ps
module nv_store_model #(
	parameter int LAT = 5
)(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic nv_wr_req,
	output logic nv_wr_done
);
	int cnt_ff;
	always_ff @(posedge clk) begin
		if (!rst_n || !nv_wr_req) begin
			cnt_ff <= 0;
			nv_wr_done <= 1'b0;
		end else if (cnt_ff == LAT) begin
			nv_wr_done <= 1'b1;
			cnt_ff <= 0;
		end else begin
			nv_wr_done <= 1'b0;
			cnt_ff <= cnt_ff + 1;
		end
	end
endmodule

// >>> verif/safety_logic_operator_library_tb.sv
`timescale 1ns/10ps
module safety_logic_operator_library_tb;
	import logic_ops_pkg::*;
	logic clk, rst_n, done, nreq, e, b;
	logic [7:0] nrs;
	apb_req_t req;
	apb_rsp_t rsp;
	logic_out_t lo;
	logic [31:0] pin, rd;
	logic [15:0] dd, dk, ds, dc, tt, tc, ri, rr, rc, dq, tq, rq, q1, q2;
	logic [7:0] ss, sr, sq, nd;
	int error_cnt, num_checks, cyc;
	safety_logic_operator_library #(.NV_WRITE_CYCLES(20), .BLINK_HALF_CYCLES(8)) i_dut (
		.clk(clk), .rst_n(rst_n), .apb_in(req), .apb_out(rsp), .logic_in(pin),
		.dff_d(dd), .capture_edge_input(dk), .dff_set(ds), .dff_clr(dc), .tff_t(tt),
		.tff_clr(tc), .sr_set(ss), .sr_rst(sr), .rs_in(ri), .rs_restart(rr), .rs_clr(rc),
		.nv_wr_done(done), .nv_restore(nrs), .logic_out(lo), .dff_q(dq), .tff_q(tq),
		.sr_q(sq), .rs_q(rq), .rs_req1(q1), .rs_req2(q2), .nv_wr_req(nreq), .nv_wr_data(nd));
	nv_store_model i_nv (.clk(clk), .rst_n(rst_n), .nv_wr_req(nreq), .nv_wr_done(done));
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	task stop_test;
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 4000) begin
			error_cnt++;
			stop_test();
		end
	end
	task chk(input string s, input logic [31:0] g, input logic [31:0] x);
		num_checks++;
		if (g !== x) begin
			error_cnt++;
			$display("MISMATCH %s exp %h got %h", s, x, g);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		req <= '{1'b1, 1'b0, w, a, d, 4'hf};
		@(posedge clk);
		req.penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (rsp.pready !== 1'b1);
		rd = rsp.prdata;
		e = rsp.pslverr;
		req <= '0;
		chk("pready", 32'(n), 32'h2);
	endtask
	task rdc(input logic [7:0] a, input logic [31:0] x, input logic ex);
		apb(1'b0, a, 32'h0);
		chk("rdata", rd, x);
		chk("slverr", 32'(e), 32'(ex));
	endtask
	task settle;
		repeat (4) @(posedge clk);
	endtask
	task mac(input logic [31:0] c, input logic [7:0] p, input logic [2:0] x);
		apb(1'b1, 8'h00, c);
		pin <= {16'h0, p, 8'h0};
		settle();
		chk("macro", 32'({lo.mac_out, lo.first_stage_result, lo.second_stage_result}), 32'(x));
	endtask
	initial begin
		rst_n = 1'b0;
		req = '0;
		nrs = '0;
		pin = '0;
		{dd, dk, ds, dc, tt, tc, ri, rr, rc} = '0;
		{ss, sr} = '0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		rdc(8'h00, 32'h0200_0112, 1'b0);
		rdc(8'h18, 32'h0, 1'b1);
		$display("registers done");
		for (int v = 0; v < 4; v++) begin
			pin <= 32'h0000_00fc | v;
			settle();
			chk("odd", 32'(lo.odd_par), 32'(^v[1:0]));
			chk("even", 32'(lo.even_par), 32'(~^v[1:0]));
		end
		for (int s = 0; s < 4; s++) begin
			pin <= 32'h0002_0000 | (s << 20);
			settle();
			chk("mux", 32'(lo.mux_out), 32'(s == 2));
		end
		$display("parity and mux done");
		apb(1'b1, 8'h04, 32'h0000_0896);
		pin <= 32'h9600_0000;
		for (int r = 0; r < 6; r++) begin
			apb(1'b1, 8'h00, 32'h0200_0112 | (r << 28));
			settle();
			chk("cmp", 32'(lo.cmp_out), 32'(6'b011010 >> r) & 32'h1);
		end
		for (int k = 0; k < 2; k++) begin
			apb(1'b1, 8'h00, 32'h0a00_0112);
			pin <= k ? 32'h5300_0000 : 32'h3500_0000;
			settle();
			chk("cmp_sig", 32'(lo.cmp_out), 32'(k));
		end
		$display("comparator done");
		mac(32'h02d0_2222, 8'h0d, 3'b011);
		mac(32'h02d0_2222, 8'h05, 3'b110);
		mac(32'h02f0_2222, 8'h05, 3'b010);
		mac(32'h02d8_2222, 8'h0d, 3'b011);
		mac(32'h02d8_2222, 8'h01, 3'b110);
		mac(32'h02d8_2222, 8'h00, 3'b100);
		apb(1'b1, 8'h20, 32'h0000_0001);
		pin <= '0;
		settle();
		chk("inv", 32'(lo.odd_par), 32'h1);
		rdc(8'h20, 32'h0000_0001, 1'b0);
		$display("macro and inversion done");
		apb(1'b1, 8'h08, 32'h0001_0000);
		{ss, sr} <= 16'h0101;
		{ds, dc, tt} <= {16'h1, 16'h1, 16'h1};
		settle();
		chk("sr", 32'(sq[0]), 32'h0);
		chk("dff", 32'(dq[0]), 32'h0);
		chk("tff", 32'(tq[0]), 32'h1);
		sr <= 8'h0;
		dc <= 16'h0;
		settle();
		chk("sr", 32'(sq[0]), 32'h1);
		chk("dff", 32'(dq[0]), 32'h1);
		repeat (20) @(posedge clk);
		rdc(8'h14, 32'h1, 1'b0);
		chk("nvdata", 32'(nd), 32'h1);
		$display("memory done");
		ri <= 16'h1;
		settle();
		chk("rs", 32'(rq[0]), 32'h0);
		chk("req1", 32'(q1[0]), 32'h1);
		b = q2[0];
		repeat (8) @(posedge clk);
		chk("blink", 32'(q2[0] ^ b), 32'h1);
		rr <= 16'h1;
		settle();
		chk("rs", 32'(rq[0]), 32'h1);
		chk("req2", 32'({q1[0], q2[0]}), 32'h0);
		ri <= 16'h0;
		settle();
		chk("rs", 32'(rq[0]), 32'h0);
		chk("req2", 32'(q2[0]), 32'h1);
		$display("restart done");
		ss <= 8'h0;
		nrs <= 8'h02;
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		settle();
		chk("restore", 32'(sq), 32'h2);
		$display("restore done");
		stop_test();
	end
endmodule

// >>> verilog/safety_logic_operator_library.sv
`timescale 1ns/10ps
`include "logic_ops_defs.svh"
module safety_logic_operator_library
	import logic_ops_pkg::*;
#(
	parameter int N_DFF = 16,
	parameter int N_TFF = 16,
	parameter int N_SR = 8,
	parameter int N_RST = 16,
	parameter int NV_WRITE_CYCLES = `NV_WRITE_MS * (`CLK_HZ / 1000),
	parameter int BLINK_HALF_CYCLES = `CLK_HZ / (2 * `BLINK_HZ)
)(
	input wire logic clk,
	input wire logic rst_n,
	input wire apb_req_t apb_in,
	output apb_rsp_t apb_out,
	input wire logic [31:0] logic_in,
	input wire logic [N_DFF-1:0] dff_d,
	input wire logic [N_DFF-1:0] capture_edge_input,
	input wire logic [N_DFF-1:0] dff_set,
	input wire logic [N_DFF-1:0] dff_clr,
	input wire logic [N_TFF-1:0] tff_t,
	input wire logic [N_TFF-1:0] tff_clr,
	input wire logic [N_SR-1:0] sr_set,
	input wire logic [N_SR-1:0] sr_rst,
	input wire logic [N_RST-1:0] rs_in,
	input wire logic [N_RST-1:0] rs_restart,
	input wire logic [N_RST-1:0] rs_clr,
	input wire logic nv_wr_done,
	input wire logic [N_SR-1:0] nv_restore,
	output logic_out_t logic_out,
	output logic [N_DFF-1:0] dff_q,
	output logic [N_TFF-1:0] tff_q,
	output logic [N_SR-1:0] sr_q,
	output logic [N_RST-1:0] rs_q,
	output logic [N_RST-1:0] rs_req1,
	output logic [N_RST-1:0] rs_req2,
	output logic nv_wr_req,
	output logic [N_SR-1:0] nv_wr_data
);
	localparam int O_DFF_D = 32;
	localparam int O_DFF_CK = O_DFF_D + N_DFF;
	localparam int O_DFF_P = O_DFF_CK + N_DFF;
	localparam int O_DFF_C = O_DFF_P + N_DFF;
	localparam int O_TFF_T = O_DFF_C + N_DFF;
	localparam int O_TFF_C = O_TFF_T + N_TFF;
	localparam int O_SR_S = O_TFF_C + N_TFF;
	localparam int O_SR_R = O_SR_S + N_SR;
	localparam int O_RS_IN = O_SR_R + N_SR;
	localparam int O_RS_RE = O_RS_IN + N_RST;
	localparam int O_RS_C = O_RS_RE + N_RST;
	localparam int TOT = O_RS_C + N_RST;
	localparam int INV_WORDS = (TOT + 31) / 32;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	// ------------------------------------------------------------------
	// Helper functions
	// ------------------------------------------------------------------
	function automatic logic [3:0] clamp_n(input logic [3:0] n, input logic [3:0] lo,
		input logic [3:0] hi);
		clamp_n = (n < lo) ? lo : ((n > hi) ? hi : n);
	endfunction

	function automatic logic [7:0] low_mask(input logic [3:0] n);
		logic [7:0] m;
		m = 8'h00;
		for (int i = 0; i < 8; i++) begin
			m[i] = (4'(i) < n);
		end
		low_mask = m;
	endfunction

	// A first-stage gate set to the flip-flop code falls back to AND.
	function automatic logic gate_eval(input gate_op_t op, input logic [7:0] v,
		input logic [3:0] n);
		logic [7:0] m;
		m = low_mask(n);
		case (op)
			GATE_NAND: gate_eval = ~&(v | ~m);
			GATE_OR: gate_eval = |(v & m);
			GATE_NOR: gate_eval = ~|(v & m);
			GATE_XOR: gate_eval = ^(v & m);
			GATE_XNOR: gate_eval = ~^(v & m);
			default: gate_eval = &(v | ~m);
		endcase
	endfunction

	function automatic logic rel_eval(input cmp_rel_t rel, input logic [7:0] x,
		input logic [7:0] y);
		case (rel)
			REL_LT: rel_eval = x < y;
			REL_LE: rel_eval = x <= y;
			REL_GT: rel_eval = x > y;
			REL_GE: rel_eval = x >= y;
			REL_EQ: rel_eval = x == y;
			REL_NE: rel_eval = x != y;
			default: rel_eval = 1'b0;
		endcase
	endfunction

	// ------------------------------------------------------------------
	// APB slave
	// ------------------------------------------------------------------
	logic [31:0] cfg_logic_ff, cfg_cmp_ff, cfg_mem_ff, cfg_rst_ff;
	logic [31:0] inv_ff [INV_WORDS];
	logic [31:0] prdata_ff, rd_data, status;
	logic pready_ff, pslverr_ff, rd_hit, acc, wr_en, inv_hit;
	logic [5:0] inv_idx;
	logic [16:0] nv_count_ff;
	logic nv_tmo_ff, wear;
	logic_out_t logic_out_ff;
	nv_state_t nv_st_ff;

	function automatic logic [31:0] strb_merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		for (int b = 0; b < 4; b++) begin
			old[b*8 +: 8] = strb[b] ? nw[b*8 +: 8] : old[b*8 +: 8];
		end
		strb_merge = old;
	endfunction

	assign acc = apb_in.psel & apb_in.penable;
	assign wr_en = acc & apb_in.pwrite & pready_ff;
	assign inv_idx = apb_in.paddr[7:2] - 6'(`OFS_INV_BASE >> 2);
	assign inv_hit = (apb_in.paddr >= `OFS_INV_BASE) && (32'(inv_idx) < INV_WORDS)
		&& (apb_in.paddr[1:0] == 2'b00);
	assign status = {22'h0, wear, nv_tmo_ff, nv_st_ff == NV_WRITE, logic_out_ff};
	assign apb_out = '{prdata: prdata_ff, pready: pready_ff, pslverr: pslverr_ff};

	always_comb begin
		rd_hit = 1'b1;
		rd_data = 32'h0;
		case (apb_in.paddr)
			`OFS_CFG_LOGIC: rd_data = cfg_logic_ff;
			`OFS_CFG_CMP: rd_data = cfg_cmp_ff;
			`OFS_CFG_MEM: rd_data = cfg_mem_ff;
			`OFS_CFG_RST: rd_data = cfg_rst_ff;
			`OFS_STATUS: rd_data = status;
			`OFS_NV_COUNT: rd_data = {15'h0, nv_count_ff};
			default: begin
				rd_hit = inv_hit;
				rd_data = inv_hit ? inv_ff[inv_idx[$clog2(INV_WORDS+1)-1:0]] : 32'h0;
			end
		endcase
	end

	// One wait state: pready rises in the second access cycle with registered data.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pready_ff <= 1'b0;
			prdata_ff <= 32'h0;
			pslverr_ff <= 1'b0;
		end else begin
			pready_ff <= acc & ~pready_ff;
			prdata_ff <= (acc & ~pready_ff & ~apb_in.pwrite) ? rd_data : 32'h0;
			pslverr_ff <= acc & ~pready_ff & ~rd_hit;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cfg_logic_ff <= `CFG_LOGIC_RST;
			cfg_cmp_ff <= `CFG_CMP_RST;
			cfg_mem_ff <= `CFG_MEM_RST;
			cfg_rst_ff <= `CFG_RST_RST;
		end else if (wr_en) begin
			case (apb_in.paddr)
				`OFS_CFG_LOGIC: cfg_logic_ff <= strb_merge(cfg_logic_ff, apb_in.pwdata, apb_in.pstrb);
				`OFS_CFG_CMP: cfg_cmp_ff <= strb_merge(cfg_cmp_ff, apb_in.pwdata, apb_in.pstrb);
				`OFS_CFG_MEM: cfg_mem_ff <= strb_merge(cfg_mem_ff, apb_in.pwdata, apb_in.pstrb);
				`OFS_CFG_RST: cfg_rst_ff <= strb_merge(cfg_rst_ff, apb_in.pwdata, apb_in.pstrb);
				default: ;
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Input synchronisers, inversion and edge detection
	// ------------------------------------------------------------------
	logic [TOT-1:0] raw_all, sync1_ff, sync2_ff, lvl, prev_ff, rise;
	logic [INV_WORDS*32-1:0] inv_vec;

	for (genvar w = 0; w < INV_WORDS; w++) begin : g_inv
		always_ff @(posedge clk) begin
			if (!rst_n) begin
				inv_ff[w] <= 32'h0;
			end else if (wr_en && inv_hit && 32'(inv_idx) == w) begin
				inv_ff[w] <= strb_merge(inv_ff[w], apb_in.pwdata, apb_in.pstrb);
			end
		end
		assign inv_vec[w*32 +: 32] = inv_ff[w];
	end

	assign raw_all = {rs_clr, rs_restart, rs_in, sr_rst, sr_set, tff_clr, tff_t, dff_clr,
		dff_set, capture_edge_input, dff_d, logic_in};

	assign lvl = sync2_ff ^ inv_vec[TOT-1:0];
	assign rise = lvl & ~prev_ff;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sync1_ff <= '0;
			sync2_ff <= '0;
			prev_ff <= '0;
		end else begin
			sync1_ff <= raw_all;
			sync2_ff <= sync1_ff;
			prev_ff <= lvl;
		end
	end

	// ------------------------------------------------------------------
	// Combinational operators
	// ------------------------------------------------------------------
	logic [7:0] mac_v, cmp_bits, cmp_val, mux_mask;
	logic [3:0] par_n, mac_n1, mac_n2, mux_n, cmp_n, operand_a_bits, operand_b_bits;
	logic [3:0] mux_select_lines, mux_data;
	logic r1, r2, mac_sr_ff, nxt_mac_sr, mux_sel_bad, cmp_res;
	logic_out_t nxt_logic_out;
	gate_op_t op1, op2, op3;
	cmp_rel_t cmp_rel;

	assign par_n = clamp_n(cfg_logic_ff[`F_PAR_N], `PAR_N_MIN, `PAR_N_MAX);
	assign mac_n1 = clamp_n(cfg_logic_ff[`F_MAC_N1], `MAC_N_MIN, `MAC_N_MAX);
	assign mac_n2 = clamp_n(cfg_logic_ff[`F_MAC_N2], `MAC_N_MIN, `MAC_N_MAX);
	assign mux_n = clamp_n({1'b0, cfg_logic_ff[`F_MUX_N]}, `MUX_N_MIN, `MUX_N_MAX);
	assign cmp_n = clamp_n(cfg_cmp_ff[`F_CMP_N], `CMP_N_MIN, `CMP_N_MAX);
	assign op1 = gate_op_t'(cfg_logic_ff[`F_MAC_OP1]);
	assign op2 = gate_op_t'(cfg_logic_ff[`F_MAC_OP2]);
	assign op3 = gate_op_t'(cfg_logic_ff[`F_MAC_OP3]);
	assign cmp_rel = cmp_rel_t'(cfg_logic_ff[`F_CMP_REL]);
	assign mac_v = lvl[15:8];
	assign mux_mask = low_mask(mux_n);
	assign mux_data = lvl[19:16] & mux_mask[3:0];
	assign mux_select_lines = lvl[23:20] & mux_mask[3:0];
	assign cmp_bits = lvl[31:24];
	assign operand_a_bits = cmp_bits[3:0];
	assign operand_b_bits = cmp_bits[7:4];
	// constant-mode value, first input as LSB
	assign cmp_val = cmp_bits & low_mask(cmp_n);
	assign mux_sel_bad = (mux_select_lines == 4'h0)
		|| ((mux_select_lines & (mux_select_lines - 4'h1)) != 4'h0);

	// two first-stage gates feeding the final gate
	always_comb begin
		r1 = (mac_n1 == 4'h1) ? mac_v[0] : gate_eval(op1, mac_v, mac_n1);
		r2 = (mac_n2 == 4'h1) ? mac_v[mac_n1[2:0]] : gate_eval(op2, mac_v >> mac_n1, mac_n2);
		nxt_mac_sr = mac_sr_ff;
		// SR function on the final gate only
		if (op3 == GATE_SRFF) begin
			nxt_mac_sr = r2 ? 1'b0 : (r1 ? 1'b1 : mac_sr_ff);
		end
		cmp_res = cfg_logic_ff[`B_CMP_SIG]
			? rel_eval(cmp_rel, {4'h0, operand_a_bits}, {4'h0, operand_b_bits})
			: rel_eval(cmp_rel, cmp_val, cfg_cmp_ff[`F_CMP_CONST]);
		nxt_logic_out.cmp_out = cmp_res;
		// forward only on a single select
		nxt_logic_out.mux_out = ~mux_sel_bad & |(mux_data & mux_select_lines);
		// optional stage outputs and main-output suppression
		nxt_logic_out.first_stage_result = cfg_logic_ff[`B_MAC_S1_EN] & r1;
		nxt_logic_out.second_stage_result = cfg_logic_ff[`B_MAC_S2_EN] & r2;
		nxt_logic_out.mac_out = ~cfg_logic_ff[`B_MAC_OUT_DIS]
			& ((op3 == GATE_SRFF) ? nxt_mac_sr : gate_eval(op3, {6'h0, r2, r1}, 4'h2));
		nxt_logic_out.odd_par = ^(lvl[7:0] & low_mask(par_n));
		nxt_logic_out.even_par = ~^(lvl[7:0] & low_mask(par_n));
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			logic_out_ff <= '{even_par: 1'b1, default: 1'b0};
			mac_sr_ff <= 1'b0;
		end else begin
			logic_out_ff <= nxt_logic_out;
			mac_sr_ff <= nxt_mac_sr;
		end
	end
	assign logic_out = logic_out_ff;

	property p_parity_pair;
		logic_out_ff.odd_par != logic_out_ff.even_par;
	endproperty
	a_parity_pair: assert property (p_parity_pair) else $error("parity outputs agree");
	property p_mux_bad_sel;
		mux_sel_bad |=> !logic_out_ff.mux_out;
	endproperty
	a_mux_bad_sel: assert property (p_mux_bad_sel) else $error("mux passes bad select");
	property p_cmp_eq;
		(!cfg_logic_ff[`B_CMP_SIG] && cmp_rel == REL_EQ && cmp_val == cfg_cmp_ff[`F_CMP_CONST]
			&& $stable(cfg_logic_ff)) |=> logic_out_ff.cmp_out;
	endproperty
	a_cmp_eq: assert property (p_cmp_eq) else $error("equal relation missed");
	property p_cmp_sig_lt;
		(cfg_logic_ff[`B_CMP_SIG] && cmp_rel == REL_LT) |=>
			logic_out_ff.cmp_out == ($past(operand_a_bits) < $past(operand_b_bits));
	endproperty
	a_cmp_sig_lt: assert property (p_cmp_sig_lt) else $error("signal compare wrong");

	// ------------------------------------------------------------------
	// Memory operators
	// ------------------------------------------------------------------
	logic [N_DFF-1:0] dff_q_ff;
	logic [N_TFF-1:0] tff_q_ff;
	logic [N_SR-1:0] sr_q_ff, sr_shadow_ff, persist_en;
	logic restored_ff;

	for (genvar i = 0; i < N_DFF; i++) begin : g_dff
		always_ff @(posedge clk) begin
			if (!rst_n) begin
				dff_q_ff[i] <= 1'b0;
			end else if (lvl[O_DFF_C+i]) begin
				dff_q_ff[i] <= 1'b0;
			end else if (lvl[O_DFF_P+i]) begin
				dff_q_ff[i] <= 1'b1;
			end else if (rise[O_DFF_CK+i]) begin
				dff_q_ff[i] <= lvl[O_DFF_D+i];
			end
		end
	end

	for (genvar i = 0; i < N_TFF; i++) begin : g_tff
		always_ff @(posedge clk) begin
			if (!rst_n) begin
				tff_q_ff[i] <= 1'b0;
			// optional clear, toggle on rising edge
			end else if (cfg_mem_ff[i] && lvl[O_TFF_C+i]) begin
				tff_q_ff[i] <= 1'b0;
			end else if (rise[O_TFF_T+i]) begin
				tff_q_ff[i] <= ~tff_q_ff[i];
			end
		end
	end

	assign persist_en = cfg_mem_ff[16 +: N_SR];
	for (genvar i = 0; i < N_SR; i++) begin : g_sr
		always_ff @(posedge clk) begin
			if (!rst_n) begin
				sr_q_ff[i] <= 1'b0;
			end else if (!restored_ff) begin
				sr_q_ff[i] <= nv_restore[i];
			end else if (lvl[O_SR_R+i]) begin
				sr_q_ff[i] <= 1'b0;
			end else if (lvl[O_SR_S+i]) begin
				sr_q_ff[i] <= 1'b1;
			end
		end
	end

	assign dff_q = dff_q_ff;
	assign tff_q = tff_q_ff;
	assign sr_q = sr_q_ff;

	property p_dff_clear;
		lvl[O_DFF_C] |=> !dff_q_ff[0];
	endproperty
	a_dff_clear: assert property (p_dff_clear) else $error("clear did not win");
	property p_dff_capture;
		(!lvl[O_DFF_C] && !lvl[O_DFF_P] && rise[O_DFF_CK]) |=> dff_q_ff[0] == $past(lvl[O_DFF_D]);
	endproperty
	a_dff_capture: assert property (p_dff_capture) else $error("data not captured");
	property p_tff_toggle;
		(rise[O_TFF_T] && !(cfg_mem_ff[0] && lvl[O_TFF_C])) |=> tff_q_ff[0] != $past(tff_q_ff[0]);
	endproperty
	a_tff_toggle: assert property (p_tff_toggle) else $error("toggle missed");
	property p_sr_reset_wins;
		(restored_ff && lvl[O_SR_S] && lvl[O_SR_R]) |=> !sr_q_ff[0];
	endproperty
	a_sr_reset_wins: assert property (p_sr_reset_wins) else $error("reset did not win");

	// ------------------------------------------------------------------
	// Non-volatile state writer
	// ------------------------------------------------------------------
	logic [31:0] nv_timer_ff;
	logic [N_SR-1:0] nv_data_ff;
	logic nv_go, nv_tmo_set, nv_tmo_clr;

	// write whenever a persisted state differs from what was stored
	assign nv_go = restored_ff && (nv_st_ff == NV_IDLE)
		&& (((sr_q_ff ^ sr_shadow_ff) & persist_en) != '0);
	// a write may last at most the write time
	assign nv_tmo_set = (nv_st_ff == NV_WRITE) && !nv_wr_done
		&& (nv_timer_ff == 32'(NV_WRITE_CYCLES - 1));
	assign nv_tmo_clr = wr_en && (apb_in.paddr == `OFS_STATUS) && apb_in.pstrb[1]
		&& apb_in.pwdata[`B_ST_NV_TMO];
	assign wear = nv_count_ff >= 17'(`NV_WEAR_LIMIT);

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			restored_ff <= 1'b0;
			sr_shadow_ff <= '0;
		end else if (!restored_ff) begin
			restored_ff <= 1'b1;
			sr_shadow_ff <= nv_restore;
		end else if (nv_go) begin
			sr_shadow_ff <= (sr_shadow_ff & ~persist_en) | (sr_q_ff & persist_en);
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			nv_st_ff <= NV_IDLE;
			nv_timer_ff <= 32'h0;
			nv_data_ff <= '0;
		end else begin
			case (nv_st_ff)
				NV_IDLE: begin
					nv_timer_ff <= 32'h0;
					if (nv_go) begin
						nv_st_ff <= NV_WRITE;
						nv_data_ff <= (sr_shadow_ff & ~persist_en) | (sr_q_ff & persist_en);
					end
				end
				NV_WRITE: begin
					nv_timer_ff <= nv_timer_ff + 32'h1;
					if (nv_wr_done || nv_tmo_set) begin
						nv_st_ff <= NV_IDLE;
					end
				end
				default: nv_st_ff <= NV_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			nv_count_ff <= 17'h0;
		end else if (nv_go && nv_count_ff != 17'h1ffff) begin
			nv_count_ff <= nv_count_ff + 17'h1;
		end
	end

	// A timeout in the clearing cycle still sets the flag.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			nv_tmo_ff <= 1'b0;
		end else begin
			nv_tmo_ff <= nv_tmo_set | (nv_tmo_ff & ~nv_tmo_clr);
		end
	end

	assign nv_wr_req = nv_st_ff == NV_WRITE;
	assign nv_wr_data = nv_data_ff;

	sequence s_nv_start;
		nv_go ##1 nv_wr_req;
	endsequence
	property p_nv_start;
		s_nv_start |-> nv_wr_data == $past(sr_q_ff & persist_en | sr_shadow_ff & ~persist_en);
	endproperty
	a_nv_start: assert property (p_nv_start) else $error("write data wrong");
	property p_nv_bound;
		nv_wr_req |-> nv_timer_ff < 32'(NV_WRITE_CYCLES);
	endproperty
	a_nv_bound: assert property (p_nv_bound) else $error("write ran too long");

	// ------------------------------------------------------------------
	// Manual restart latches
	// ------------------------------------------------------------------
	logic [31:0] blink_cnt_ff;
	logic blink_ff;
	logic [N_RST-1:0] rs_q_ff, rs_req1_ff, rs_req2_ff, rs_off;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			blink_cnt_ff <= 32'h0;
			blink_ff <= 1'b0;
		end else if (blink_cnt_ff == 32'(BLINK_HALF_CYCLES - 1)) begin
			blink_cnt_ff <= 32'h0;
			blink_ff <= ~blink_ff;
		end else begin
			blink_cnt_ff <= blink_cnt_ff + 32'h1;
		end
	end

	// instance count is a module parameter
	for (genvar i = 0; i < N_RST; i++) begin : g_rs
		assign rs_off[i] = (cfg_rst_ff[i] & lvl[O_RS_C+i]) | ~lvl[O_RS_IN+i];
		always_ff @(posedge clk) begin
			if (!rst_n) begin
				rs_q_ff[i] <= 1'b0;
				rs_req1_ff[i] <= 1'b0;
				rs_req2_ff[i] <= 1'b1;
			end else begin
				// enabled clear (cfg_rst_ff bit) or false input resets, restart edge sets
				rs_q_ff[i] <= !rs_off[i] && (rs_q_ff[i] || rise[O_RS_RE+i]);
				rs_req1_ff[i] <= !rs_off[i] && !rs_q_ff[i] && !rise[O_RS_RE+i];
				rs_req2_ff[i] <= rs_off[i]
					|| (!rs_q_ff[i] && !rise[O_RS_RE+i] && blink_ff);
			end
		end
	end

	assign rs_q = rs_q_ff;
	assign rs_req1 = rs_req1_ff;
	assign rs_req2 = rs_req2_ff;

	property p_rs_off;
		rs_off[0] |=> !rs_q_ff[0] && !rs_req1_ff[0] && rs_req2_ff[0];
	endproperty
	a_rs_off: assert property (p_rs_off) else $error("latch not cleared");
	property p_rs_set;
		(!rs_off[0] && rise[O_RS_RE]) |=> rs_q_ff[0] && !rs_req2_ff[0];
	endproperty
	a_rs_set: assert property (p_rs_set) else $error("restart edge missed");
endmodule
